// [logic/framer_pkg.sv]
// Shared constants, types and helpers of the diskette track framer.
package framer_pkg;

   // ------------------------------------------------------------
   // Bit cell timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ  = 40;
   localparam int CELL_NS  = 2000;
   localparam int HALF_NS  = 1000;
   localparam int CELL_CYC = (CELL_NS * CLK_MHZ + 999) / 1000;
   localparam int HALF_CYC = (HALF_NS * CLK_MHZ + 999) / 1000;

   // ------------------------------------------------------------
   // Track layout
   // ------------------------------------------------------------
   localparam int NUM_RECORDS = 52;
   localparam int GAP_POST    = 28;
   localparam int GAP_ID      = 28;
   localparam int GAP_DATA    = 28;
   localparam int GAP_PRE     = 338;
   localparam int ID_BYTES    = 4;
   localparam int DATA_BYTES  = 128;
   localparam logic [7:0] FILL_BYTE = 8'h00;

   // ------------------------------------------------------------
   // Address marks and CRC
   // ------------------------------------------------------------
   localparam logic [2:0]  MARK_CELL  = 3'h2;
   localparam int          MARK_CBIT  = 5;
   localparam logic [7:0]  AM_INDEX   = 8'h4C;
   localparam logic [7:0]  AM_ID      = 8'h4E;
   localparam logic [7:0]  AM_DATA    = 8'h4B;
   localparam logic [7:0]  AM_DELETED = 8'h48;
   localparam logic [15:0] CRC_POLY   = 16'h1021;
   localparam logic [15:0] CRC_PRESET = 16'hFFFF;

   typedef enum logic [1:0] {
      K_INDEX = 2'h0,
      K_ID    = 2'h1,
      K_DATA  = 2'h2,
      K_DEL   = 2'h3
   } mark_kind_t;

   typedef enum logic [6:0] {
      S_IDLE   = 7'h01,
      S_MARK   = 7'h02,
      S_BODY   = 7'h04,
      S_CRC_HI = 7'h08,
      S_CRC_LO = 7'h10,
      S_GAP    = 7'h20,
      S_FLUSH  = 7'h40
   } wr_state_t;

   function automatic logic [7:0] mark_byte(input mark_kind_t k);
      unique case (k)
         K_INDEX: mark_byte = AM_INDEX;
         K_ID:    mark_byte = AM_ID;
         K_DATA:  mark_byte = AM_DATA;
         K_DEL:   mark_byte = AM_DELETED;
      endcase
   endfunction : mark_byte

   // Clock pulse only when this cell and the one before are empty.
   function automatic logic m2fm_clk(input logic d, input logic pd,
                                     input logic pc);
      m2fm_clk = !d && !pd && !pc;
   endfunction : m2fm_clk

endpackage : framer_pkg

// [logic/crc16_unit.sv]
// Byte-wide CRC register with preset, used on both write and read paths.
module crc16_unit
   import framer_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        init_i,
   input  wire logic        valid_i,
   input  wire logic [7:0]  byte_i,
   output logic      [15:0] crc_o
);

   typedef struct packed {
      logic [15:0] crc;
   } crc_state_t;

   crc_state_t q, n;

   // Divides by the generator, most significant bit first.
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0]  b);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[15] ^ b[i];
         r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      crc_step = r;
   endfunction : crc_step

   always_comb begin
      n = q;
      if (init_i) begin
         n.crc = valid_i ? crc_step(CRC_PRESET, byte_i) : CRC_PRESET;
      end else if (valid_i) begin
         n.crc = crc_step(q.crc, byte_i);
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{crc: CRC_PRESET};
      end else begin
         q <= n;
      end
   end

   assign crc_o = q.crc;

endmodule : crc16_unit

// [logic/diskette_track_framer_crc.sv]
// Track formatter, field writer and field reader with CRC.

module diskette_track_framer_crc
   import framer_pkg::*;
#(
   parameter int ID_LEN   = ID_BYTES,
   parameter int DATA_LEN = DATA_BYTES,
   parameter int REC_N    = NUM_RECORDS
) (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_i,
   input  wire logic       fmt_start_i,
   input  wire logic       wr_start_i,
   input  wire logic       wr_deleted_i,
   input  wire logic [7:0] wr_byte_i,
   output logic            wr_take_o,
   output logic            wr_gate_o,
   output logic            wr_flux_o,
   output logic            wr_busy_o,
   output logic            wr_done_o,
   input  wire logic       rd_en_i,
   input  wire logic       rd_flux_i,
   output logic            rd_mark_o,
   output logic [1:0]      rd_kind_o,
   output logic [7:0]      rd_byte_o,
   output logic            rd_valid_o,
   output logic            rd_done_o,
   output logic            rd_crc_err_o
);

   // ------------------------------------------------------------
   // Parameter checks and local constants
   // ------------------------------------------------------------
   if (ID_LEN < 1 || DATA_LEN < 1 || DATA_LEN > 500 || ID_LEN > 500 ||
       REC_N < 1 || REC_N > 63) begin : g_bad_param
      $error("Field length or record count out of range.");
   end

   localparam logic [6:0] CELL_LAST = 7'(CELL_CYC - 1);
   localparam logic [6:0] HALF_Q    = 7'(HALF_CYC);
   localparam logic [6:0] CLK_MID   = 7'(HALF_CYC / 2);
   localparam logic [6:0] DAT_MID   = 7'(HALF_CYC + HALF_CYC / 2);
   localparam logic [5:0] REC_Q     = 6'(REC_N);
   localparam int         CELL_N    = CELL_CYC;

   function automatic logic [8:0] fld_len(input mark_kind_t k);
      unique case (k)
         K_INDEX:       fld_len = 9'h000;
         K_ID:          fld_len = 9'(ID_LEN);
         K_DATA, K_DEL: fld_len = 9'(DATA_LEN);
      endcase
   endfunction : fld_len

   typedef struct packed {
      wr_state_t  st;
      mark_kind_t kind;
      logic       fmt;
      logic [5:0] rec;
      logic [8:0] cnt;
      logic [7:0] sh;
      logic       mark;
      logic [2:0] bitn;
      logic [6:0] phase;
      logic       cell_c;
      logic       cell_d;
      logic       prev_c;
      logic       prev_d;
      logic       gate;
      logic       flux;
      logic       take;
      logic       busy;
      logic       done;
      logic [2:0] sync;
      logic       lvl;
      logic [6:0] rph;
      logic       got_c;
      logic       got_d;
      logic [7:0] dsh;
      logic [7:0] csh;
      logic       infield;
      logic [2:0] rbit;
      logic [8:0] rem;
      mark_kind_t rkind;
      logic       rmark;
      logic [7:0] rbyte;
      logic       rvalid;
      logic       chk;
      logic       rdone;
      logic       err;
   } state_t;

   localparam state_t Q_RST = '{st: S_IDLE, kind: K_INDEX, rkind: K_INDEX,
                                default: '0};

   state_t      q, n;
   logic        w_init, w_val, r_init, r_val;
   logic [7:0]  w_byte, nd, nc;
   logic [15:0] wcrc, rcrc;
   logic        load, byte_end, newcell, edge_seen, mfound;
   mark_kind_t  mkind;

   crc16_unit u_wcrc (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .init_i    (w_init),
      .valid_i   (w_val),
      .byte_i    (w_byte),
      .crc_o     (wcrc)
   );

   crc16_unit u_rcrc (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .init_i    (r_init),
      .valid_i   (r_val),
      .byte_i    (nd),
      .crc_o     (rcrc)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      n         = q;
      n.take    = 1'b0;
      n.done    = 1'b0;
      n.rmark   = 1'b0;
      n.rvalid  = 1'b0;
      n.chk     = 1'b0;
      n.rdone   = 1'b0;
      w_init    = 1'b0;
      w_val     = 1'b0;
      w_byte    = FILL_BYTE;
      r_init    = 1'b0;
      r_val     = 1'b0;
      newcell   = 1'b0;
      mfound    = 1'b0;
      mkind     = K_INDEX;
      byte_end  = q.busy && q.phase == CELL_LAST && q.bitn == 3'h7;
      load      = q.st != S_IDLE && q.st != S_FLUSH && (!q.busy || byte_end);

      // Write cell timing.
      if (q.busy) begin
         n.phase = q.phase + 7'h01;
         if (q.phase == CELL_LAST) begin
            n.phase = 7'h00;
            if (q.bitn != 3'h7) begin
               n.bitn  = q.bitn + 3'h1;
               n.sh    = {q.sh[6:0], 1'b0};
               newcell = 1'b1;
            end
         end
      end

      unique case (q.st)
         S_IDLE: begin
            if (fmt_start_i || wr_start_i) begin
               n.st   = S_MARK;
               n.fmt  = fmt_start_i;
               n.rec  = 6'h00;
               n.kind = fmt_start_i ? K_INDEX
                      : (wr_deleted_i ? K_DEL : K_DATA);
            end
         end
         S_MARK: begin
            if (load) begin
               w_byte = mark_byte(q.kind);
               w_init = 1'b1;
               w_val  = 1'b1;
               n.mark = 1'b1;
               if (q.kind == K_INDEX) begin
                  n.st   = S_GAP;
                  n.cnt  = 9'(GAP_POST);
                  n.kind = K_ID;
               end else begin
                  n.st  = S_BODY;
                  n.cnt = fld_len(q.kind);
               end
            end
         end
         S_BODY: begin
            if (load) begin
               w_byte = wr_byte_i;
               w_val  = 1'b1;
               n.take = 1'b1;
               n.cnt  = q.cnt - 9'h001;
               if (q.cnt == 9'h001) n.st = S_CRC_HI;
            end
         end
         S_CRC_HI: begin
            if (load) begin
               w_byte = wcrc[15:8];
               n.st   = S_CRC_LO;
            end
         end
         S_CRC_LO: begin
            if (load) begin
               w_byte = wcrc[7:0];
               n.st   = S_GAP;
               if (!q.fmt) begin
                  n.st = S_FLUSH;
               end else if (q.kind == K_ID) begin
                  n.cnt  = 9'(GAP_ID);
                  n.kind = K_DATA;
               end else if (q.rec + 6'h01 == REC_Q) begin
                  n.rec  = q.rec + 6'h01;
                  n.cnt  = 9'(GAP_PRE);
                  n.kind = K_INDEX;
               end else begin
                  n.rec  = q.rec + 6'h01;
                  n.cnt  = 9'(GAP_DATA);
                  n.kind = K_ID;
               end
            end
         end
         S_GAP: begin
            if (load) begin
               w_byte = FILL_BYTE;
               n.cnt  = q.cnt - 9'h001;
               if (q.cnt == 9'h001) begin
                  n.st = (q.kind == K_INDEX) ? S_FLUSH : S_MARK;
               end
            end
         end
         S_FLUSH: begin
            if (byte_end) begin
               n.st     = S_IDLE;
               n.busy   = 1'b0;
               n.gate   = 1'b0;
               n.done   = 1'b1;
               n.cell_c = 1'b0;
               n.cell_d = 1'b0;
               n.phase  = 7'h00;
            end
         end
         default: n = Q_RST;
      endcase

      if (load) begin
         n.sh    = w_byte;
         n.mark  = q.st == S_MARK;
         n.bitn  = 3'h0;
         n.phase = 7'h00;
         n.busy  = 1'b1;
         n.gate  = 1'b1;
         newcell = 1'b1;
      end
      if (newcell) begin
         n.prev_c = q.cell_c;
         n.prev_d = q.cell_d;
         n.cell_d = n.sh[7];
         n.cell_c = (n.mark && n.bitn == MARK_CELL) ||
                    m2fm_clk(n.sh[7], q.cell_d, q.cell_c);
      end
      n.flux = n.gate && (n.phase < HALF_Q ? n.cell_c : n.cell_d);

      // Read side: filtered pulse edge and cell recovery.
      n.sync    = {q.sync[1:0], rd_flux_i};
      edge_seen = 1'b0;
      if (q.sync[1] == q.sync[2]) begin
         n.lvl     = q.sync[2];
         edge_seen = q.sync[2] && !q.lvl;
      end
      nd = {q.dsh[6:0], q.got_d};
      nc = {q.csh[6:0], q.got_c};
      if (!rd_en_i) begin
         n.rph     = 7'h00;
         n.infield = 1'b0;
         n.got_c   = 1'b0;
         n.got_d   = 1'b0;
      end else if (edge_seen) begin
         if (q.rph < HALF_Q) begin
            n.got_c = 1'b1;
            n.rph   = CLK_MID;
         end else begin
            n.got_d = 1'b1;
            n.rph   = DAT_MID;
         end
      end else if (q.rph == CELL_LAST) begin
         n.rph   = 7'h00;
         n.got_c = 1'b0;
         n.got_d = 1'b0;
         n.dsh   = nd;
         n.csh   = nc;
         for (int k = 0; k < 4; k++) begin
            if (nd == mark_byte(mark_kind_t'(k)) && nc[MARK_CBIT]) begin
               mfound = 1'b1;
               mkind  = mark_kind_t'(k);
            end
         end
         if (mfound) begin
            n.rmark   = 1'b1;
            n.rkind   = mkind;
            n.rbit    = 3'h0;
            n.infield = mkind != K_INDEX;
            n.rem     = fld_len(mkind) + 9'h002;
            r_init    = 1'b1;
            r_val     = 1'b1;
         end else if (q.infield) begin
            n.rbit = q.rbit + 3'h1;
            if (q.rbit == 3'h7) begin
               r_val  = 1'b1;
               n.rem  = q.rem - 9'h001;
               n.rbyte = nd;
               n.rvalid = q.rem > 9'h002;
               if (q.rem == 9'h001) begin
                  n.infield = 1'b0;
                  n.chk     = 1'b1;
               end
            end
         end
      end else begin
         n.rph = q.rph + 7'h01;
      end
      if (q.chk) begin
         n.rdone = 1'b1;
         n.err   = rcrc != 16'h0000;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= Q_RST;
      end else begin
         q <= n;
      end
   end

   assign wr_take_o    = q.take;
   assign wr_gate_o    = q.gate;
   assign wr_flux_o    = q.flux;
   assign wr_busy_o    = q.busy;
   assign wr_done_o    = q.done;
   assign rd_mark_o    = q.rmark;
   assign rd_kind_o    = q.rkind;
   assign rd_byte_o    = q.rbyte;
   assign rd_valid_o   = q.rvalid;
   assign rd_done_o    = q.rdone;
   assign rd_crc_err_o = q.err;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [8:0] gap_run_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_run_q <= 9'h000;
      end else if (q.st != S_GAP) begin
         gap_run_q <= 9'h000;
      end else if (load) begin
         gap_run_q <= gap_run_q + 9'h001;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_crc_hi_load;
      load && q.st == S_CRC_HI;
   endsequence

   sequence s_crc_lo_load;
      load && q.st == S_CRC_LO;
   endsequence

   sequence s_cell_start;
      q.gate && q.phase == 7'h00;
   endsequence

   a_gap_filler: assert property ((load && q.st == S_GAP) |=>
      (q.sh == FILL_BYTE && !q.mark))
      else $error("Gap byte is not filler.");
   a_gap_length: assert property (
      (load && q.st == S_GAP && q.cnt == 9'h001) |->
      (gap_run_q == 9'(GAP_POST - 1) || gap_run_q == 9'(GAP_PRE - 1)))
      else $error("Gap length wrong.");
   a_mark_clock: assert property ((q.gate && q.mark &&
      q.bitn == MARK_CELL) |-> q.cell_c)
      else $error("Mark lacks extra clock in cell 2.");
   a_m2fm_rule: assert property ((q.gate &&
      !(q.mark && q.bitn == MARK_CELL)) |->
      q.cell_c == (!q.cell_d && !q.prev_d && !q.prev_c))
      else $error("Clock bit breaks encoding.");
   a_cell_period: assert property (s_cell_start |->
      ##CELL_N (q.phase == 7'h00 || !q.gate))
      else $error("Bit cell period wrong.");
   a_crc_bytes: assert property (s_crc_hi_load |=>
      (q.sh == $past(wcrc[15:8]) && q.st == S_CRC_LO))
      else $error("CRC high byte not sent.");
   a_crc_low: assert property (s_crc_lo_load |=>
      (q.sh == $past(wcrc[7:0])))
      else $error("CRC low byte not sent.");
   a_msb_first: assert property (s_cell_start |->
      q.cell_d == q.sh[7])
      else $error("Cell data is not the byte MSB.");
   a_read_align: assert property (q.rmark |->
      (q.rbit == 3'h0 && q.infield == (q.rkind != K_INDEX)))
      else $error("Byte boundary not aligned on mark.");
   a_read_crc: assert property (q.rdone |->
      q.err == (rcrc != 16'h0000))
      else $error("CRC verdict wrong.");
   a_record_cnt: assert property ((q.done && q.fmt) |->
      q.rec == REC_Q)
      else $error("Track record count wrong.");

endmodule : diskette_track_framer_crc

// [testbench/drive_model.sv]
// Behavioural drive head: records written cells and replays them.
module drive_model (
   input  wire logic        sys_clk_i,
   input  wire logic        gate_i,
   input  wire logic        flux_i,
   input  wire logic        play_i,
   input  wire logic [9:0]  flip_i,
   output logic             flux_o,
   output logic             byte_o,
   output logic             first_o,
   output logic [15:0]      cells_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] trk [1024];
   logic [1:0] cb;
   logic       gq;
   int         n;
   int         ph;
   int         k;
   int         c;
   initial begin
      n = 0;
      ph = 0;
      gq = 0;
      flux_o = 0;
      byte_o = 0;
      first_o = 0;
      cells_o = 0;
   end
   // Cells are sampled mid-window, counted from the rise of the gate.
   always @(posedge sys_clk_i) begin
      byte_o <= 0;
      if (gate_i && !gq) begin
         n = 0;
         ph = 0;
      end
      if (gate_i) begin
         if (ph == 20) trk[n][1] = flux_i;
         if (ph == 60) begin
            trk[n][0] = flux_i;
            cells_o = {cells_o[13:0], trk[n]};
            n++;
            if (n % 8 == 0) begin
               byte_o <= 1;
               first_o <= (n == 8);
            end
         end
         ph = (ph == 79) ? 0 : ph + 1;
      end
      gq = gate_i;
   end
   // Replay: filler lead-in, recorded cells, then a silent tail.
   initial forever begin
      @(posedge sys_clk_i);
      if (play_i) begin
         for (k = -16; k < n + 8; k++) begin
            cb = (k < 0) ? {~k[0], 1'b0} : (k < n) ? trk[k] : 2'b00;
            if (k == int'(flip_i)) cb[0] = ~cb[0];
            for (c = 0; c < 80; c++) begin
               flux_o <= (c >= 10 && c < 16 && cb[1]) ||
                         (c >= 50 && c < 56 && cb[0]);
               @(posedge sys_clk_i);
            end
         end
         flux_o <= 0;
      end
   end
endmodule : drive_model

// [testbench/diskette_track_framer_crc_bench.sv]
// Self-checking bench for the track framer with a drive model.
module diskette_track_framer_crc_bench;
   import framer_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DL = 2;
   logic sys_clk_i = 0, rst_i = 1, fmt_start_i = 0, wr_start_i = 0;
   logic wr_deleted_i = 0, rd_en_i = 0, rd_flux_i, play_i = 0;
   logic [7:0] wr_byte_i = 8'h00;
   logic [9:0] flip_i = 10'h3FF;
   logic wr_take_o, wr_gate_o, wr_flux_o, wr_busy_o, wr_done_o;
   logic rd_mark_o, rd_valid_o, rd_done_o, rd_crc_err_o;
   logic [1:0] rd_kind_o;
   logic [7:0] rd_byte_o;
   logic ser_byte, ser_first, pd, pc;
   logic [15:0] ser_cells;
   logic [8:0] ser_q[$];
   logic [7:0] rd_q[$];
   logic [1:0] kind_q[$];
   logic err_q[$];
   int seed = 32'h5445, mismatches = 0, cmp_count = 0, t;

   always #12.5 sys_clk_i = ~sys_clk_i;

   diskette_track_framer_crc #(.ID_LEN(1), .DATA_LEN(DL), .REC_N(2)) uut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .fmt_start_i(fmt_start_i),
      .wr_start_i(wr_start_i), .wr_deleted_i(wr_deleted_i),
      .wr_byte_i(wr_byte_i), .wr_take_o(wr_take_o), .wr_gate_o(wr_gate_o),
      .wr_flux_o(wr_flux_o), .wr_busy_o(wr_busy_o), .wr_done_o(wr_done_o),
      .rd_en_i(rd_en_i), .rd_flux_i(rd_flux_i), .rd_mark_o(rd_mark_o),
      .rd_kind_o(rd_kind_o), .rd_byte_o(rd_byte_o), .rd_valid_o(rd_valid_o),
      .rd_done_o(rd_done_o), .rd_crc_err_o(rd_crc_err_o));

   drive_model drive (.sys_clk_i(sys_clk_i), .gate_i(wr_gate_o),
      .flux_i(wr_flux_o), .play_i(play_i), .flip_i(flip_i),
      .flux_o(rd_flux_i), .byte_o(ser_byte), .first_o(ser_first),
      .cells_o(ser_cells));

   task automatic chk(input string nm, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim

   // Expected clock/data cell pairs of one byte, cell 0 first.
   function automatic logic [15:0] cells(input logic [8:0] v);
      logic d, c;
      logic [15:0] r;
      for (int i = 0; i < 8; i++) begin
         d = v[7 - i];
         c = (!d && !pd && !pc) || (v[8] && i == 2);
         r = {r[13:0], c, d};
         pd = d;
         pc = c;
      end
      return r;
   endfunction : cells

   function automatic logic [15:0] crc(input logic [15:0] r,
                                       input logic [7:0]  b);
      for (int i = 7; i >= 0; i--)
         r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? CRC_POLY : 16'h0000);
      return r;
   endfunction : crc

   // ------------------------------------------------------------
   // Output watcher
   // ------------------------------------------------------------
   always @(posedge sys_clk_i) begin : watch
      logic [15:0] m;
      if (ser_byte && ser_q.size() > 0) begin
         // The first cell's clock depends on history before the gate.
         m = ser_first ? 16'h7FFF : 16'hFFFF;
         if (ser_first) begin
            pd = 0;
            pc = 0;
         end
         m = cells(ser_q.pop_front()) & m;
         chk("serial cells", m, ser_cells & m);
      end
      if (rd_valid_o)
         chk("read byte", rd_q.size() ? rd_q.pop_front() : 'x,
             rd_byte_o);
      if (rd_mark_o)
         chk("mark kind", kind_q.size() ? kind_q.pop_front() : 'x,
             rd_kind_o);
      if (rd_done_o)
         chk("crc error", err_q.size() ? err_q.pop_front() : 'x,
             rd_crc_err_o);
   end

   task automatic do_write(input logic del, input logic bad);
      logic [7:0] b[DL];
      logic [15:0] r;
      int i;
      r = crc(CRC_PRESET, del ? AM_DELETED : AM_DATA);
      ser_q.push_back({1'b1, del ? AM_DELETED : AM_DATA});
      for (i = 0; i < DL; i++) begin
         b[i] = $random(seed);
         r = crc(r, b[i]);
         ser_q.push_back({1'b0, b[i]});
         rd_q.push_back((i == 0 && bad) ? b[i] ^ 8'h08 : b[i]);
      end
      ser_q.push_back({1'b0, r[15:8]});
      ser_q.push_back({1'b0, r[7:0]});
      kind_q.push_back(del ? 2'h3 : 2'h2);
      err_q.push_back(bad);
      wr_start_i <= 1;
      wr_deleted_i <= del;
      wr_byte_i <= b[0];
      @(posedge sys_clk_i);
      wr_start_i <= 0;
      i = 0;
      t = 0;
      while (!wr_done_o && t < 9000) begin
         @(posedge sys_clk_i);
         t++;
         if (wr_take_o) begin
            i++;
            wr_byte_i <= (i < DL) ? b[i] : 8'($random(seed));
         end
         wr_start_i <= (t == 900);
      end
      chk("bytes taken", 16'(DL), 16'(i));
      chk("write done", 1, wr_done_o);
      rd_en_i <= 1;
      play_i <= 1;
      flip_i <= bad ? 10'd12 : 10'h3FF;
      @(posedge sys_clk_i);
      play_i <= 0;
      t = 0;
      while ((err_q.size() || ser_q.size()) && t < 8000) begin
         @(posedge sys_clk_i);
         t++;
      end
      chk("fields open", 0, 16'(err_q.size() + ser_q.size()));
      rd_en_i <= 0;
      @(posedge sys_clk_i);
   endtask : do_write

   initial begin
      repeat (10) @(posedge sys_clk_i);
      rst_i <= 0;
      @(posedge sys_clk_i);
      chk("idle outputs", 0, {wr_gate_o, wr_busy_o, wr_done_o, wr_take_o,
          rd_valid_o, rd_done_o, rd_mark_o, rd_kind_o});
      for (int j = 0; j < 4; j++) do_write(j[0], j[1]);
      ser_q.push_back({1'b1, AM_INDEX});
      repeat (GAP_POST) ser_q.push_back({1'b0, FILL_BYTE});
      ser_q.push_back({1'b1, AM_ID});
      fmt_start_i <= 1;
      @(posedge sys_clk_i);
      fmt_start_i <= 0;
      t = 0;
      while (ser_q.size() && t < 25000) begin
         @(posedge sys_clk_i);
         t++;
      end
      chk("format lead-in", 0, 16'(ser_q.size()));
      rst_i <= 1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 0;
      @(posedge sys_clk_i);
      chk("gate after reset", 0, {wr_gate_o, wr_busy_o});
      end_sim;
   end

   initial begin
      repeat (90000) @(posedge sys_clk_i);
      mismatches++;
      end_sim;
   end
endmodule : diskette_track_framer_crc_bench
